//--- rtl/serial_port_ctrl.sv
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
// How it works
// RULE1: Mode bits pick sync 8-bit, async 10-bit variable, 11-bit fixed or 11-bit variable rate.
// RULE2: Control bit 7 is the upper mode bit, or the framing flag while framing select is set.
// RULE3: With framing select set, a received stop bit of zero sets the framing flag.
// RULE4: Software clears the framing flag; hardware never does.
// RULE5: In modes 2 and 3 with multiprocessor set, a zero ninth bit raises no receive-done flag.
// RULE6: In mode 1 with multiprocessor set, an invalid stop bit raises no receive-done flag.
// RULE7: In mode 0 the multiprocessor bit picks 12 clocks per bit at 0 and 4 clocks at 1.
// RULE8: Reception runs only while receive enable is 1.
// RULE9: In modes 2 and 3 the software ninth bit goes out as the ninth data bit.
// RULE10: The received ninth bit is bit 9 in modes 2 and 3 and the stop bit in mode 1 at mp 0.
// RULE11: Transmit-done sets after bit 8 in mode 0, at the start of the stop bit otherwise.
// RULE12: Software clears transmit-done; hardware never does.
// RULE13: Receive-done sets after bit 8 in mode 0, mid stop bit otherwise, after filtering.
// RULE14: Only software clears receive-done.
// RULE15: Baud double halves the bit time in modes 1, 2 and 3.
// RULE16: The data address reads the receive register and writes the transmit buffer.
// RULE17: Writing the transmit buffer while idle sends one frame in the current mode.
module serial_port_ctrl (
  // AHB-Lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Serial pins; rxd is two-way in mode 0
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd,
  // Interrupt
  output logic irq
);
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_RUN = 2'b10} rx_state_e;

  function automatic logic [15:0] bit_clks(input logic [1:0] m, input logic mp,
                                           input logic dbl, input logic [7:0] rl);
    logic [15:0] base;
    base = {8'h00, rl} + 16'h0001;
    case (m)
      serial_port_pkg::MODE_SYNC: bit_clks = mp ? serial_port_pkg::M0_FAST
                                                : serial_port_pkg::M0_SLOW; // RULE7
      serial_port_pkg::MODE_FIXED11: bit_clks = dbl ? serial_port_pkg::M2_FAST
                                                    : serial_port_pkg::M2_SLOW; // RULE15
      default: bit_clks = dbl ? base : {base[14:0], 1'b0}; // RULE15
    endcase
  endfunction

  function automatic logic [3:0] frame_bits(input logic [1:0] m);
    case (m)
      serial_port_pkg::MODE_SYNC: frame_bits = serial_port_pkg::NB_SYNC;
      serial_port_pkg::MODE_ASYNC10: frame_bits = serial_port_pkg::NB_TEN;
      default: frame_bits = serial_port_pkg::NB_ELEVEN;
    endcase
  endfunction

  localparam int IRQ_W_L = serial_port_pkg::IRQ_W;
  localparam int ADDR_HI_L = serial_port_pkg::ADDR_HI;
  localparam int ADDR_LO_L = serial_port_pkg::ADDR_LO;

  // Bus state
  logic [7:0] a_idx_reg, a_idx_next;
  logic a_wr_reg, a_wr_next, a_rd_reg, a_rd_next;
  logic hready_reg, hready_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [7:0] rd_val;
  // Port state
  logic mode_hi_reg, mode_hi_next, mode_lo_reg, mode_lo_next;
  logic mp_reg, mp_next, ren_reg, ren_next, tx9_reg, tx9_next, rx9_reg, rx9_next;
  logic txf_reg, txf_next, rxf_reg, rxf_next, ferr_reg, ferr_next;
  logic dbl_reg, dbl_next, fsel_reg, fsel_next;
  logic [7:0] baud_reg, baud_next, rbuf_reg, rbuf_next;
  logic [IRQ_W_L-1:0] istat_reg, istat_next, imask_reg, imask_next;
  tx_state_e tx_st_reg, tx_st_next;
  rx_state_e rx_st_reg, rx_st_next;
  logic [10:0] tx_sh_reg, tx_sh_next;
  logic [15:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
  logic [3:0] tx_idx_reg, tx_idx_next, rx_idx_reg, rx_idx_next;
  logic [7:0] rx_data_reg, rx_data_next;
  logic nine_reg, nine_next;
  logic rxd_s1_reg, rxd_s2_reg, rxd_s3_reg;
  logic txd_reg, txd_next, rxd_out_reg, rxd_out_next, rxd_oe_reg, rxd_oe_next;
  logic irq_reg, irq_next;
  // Shared terms
  logic [1:0] mode;
  logic [15:0] per, half;
  logic [3:0] nb;
  logic [7:0] wdata;
  logic tx_ev, rx_ev, ferr_ev, stop_bit, accept;

  assign mode = {mode_hi_reg, mode_lo_reg}; // RULE1
  assign per = bit_clks(mode, mp_reg, dbl_reg, baud_reg);
  assign half = {1'b0, per[15:1]};
  assign nb = frame_bits(mode); // RULE1
  assign wdata = hwdata[7:0];

  // Bus: writes take no wait state, reads take one so read data comes from a flop
  always_comb begin
    a_wr_next = 1'b0;
    a_rd_next = 1'b0;
    a_idx_next = a_idx_reg;
    hrdata_next = hrdata_reg;
    hready_next = 1'b1;
    if (hsel && hready && htrans[1]) begin
      a_idx_next = (haddr[31:ADDR_HI_L+1] == '0) ? haddr[ADDR_HI_L:ADDR_LO_L]
                                                 : serial_port_pkg::IDX_NONE;
      a_wr_next = hwrite;
      a_rd_next = !hwrite;
      hready_next = hwrite;
    end
    if (a_rd_reg) begin
      hrdata_next = {24'h000000, rd_val};
    end
  end

  always_comb begin
    case (a_idx_reg)
      serial_port_pkg::IDX_CTRL: rd_val = {fsel_reg ? ferr_reg : mode_hi_reg, // RULE2
                                           mode_lo_reg, mp_reg, ren_reg, tx9_reg,
                                           rx9_reg, txf_reg, rxf_reg};
      serial_port_pkg::IDX_DATA: rd_val = rbuf_reg; // RULE16
      serial_port_pkg::IDX_POWER: rd_val = {dbl_reg, fsel_reg, 6'h00};
      serial_port_pkg::IDX_BAUD: rd_val = baud_reg;
      serial_port_pkg::IDX_ISTAT: rd_val = {5'h00, istat_reg};
      serial_port_pkg::IDX_IMASK: rd_val = {5'h00, imask_reg};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_idx_reg <= serial_port_pkg::IDX_NONE;
      a_wr_reg <= 1'b0;
      a_rd_reg <= 1'b0;
      hready_reg <= 1'b1;
      hrdata_reg <= 32'h00000000;
    end else begin
      a_idx_reg <= a_idx_next;
      a_wr_reg <= a_wr_next;
      a_rd_reg <= a_rd_next;
      hready_reg <= hready_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // Port core; software writes are applied first so a hardware set wins
  always_comb begin
    mode_hi_next = mode_hi_reg;
    mode_lo_next = mode_lo_reg;
    mp_next = mp_reg;
    ren_next = ren_reg;
    tx9_next = tx9_reg;
    rx9_next = rx9_reg;
    txf_next = txf_reg;
    rxf_next = rxf_reg;
    ferr_next = ferr_reg;
    dbl_next = dbl_reg;
    fsel_next = fsel_reg;
    baud_next = baud_reg;
    rbuf_next = rbuf_reg;
    imask_next = imask_reg;
    istat_next = istat_reg;
    tx_st_next = tx_st_reg;
    rx_st_next = rx_st_reg;
    tx_sh_next = tx_sh_reg;
    tx_cnt_next = tx_cnt_reg;
    rx_cnt_next = rx_cnt_reg;
    tx_idx_next = tx_idx_reg;
    rx_idx_next = rx_idx_reg;
    rx_data_next = rx_data_reg;
    nine_next = nine_reg;
    tx_ev = 1'b0;
    rx_ev = 1'b0;
    ferr_ev = 1'b0;
    stop_bit = rxd_s2_reg;
    accept = 1'b0;
    if (a_wr_reg) begin
      case (a_idx_reg)
        serial_port_pkg::IDX_CTRL: begin
          if (fsel_reg) begin
            ferr_next = wdata[serial_port_pkg::CTL_HI]; // RULE4
          end else begin
            mode_hi_next = wdata[serial_port_pkg::CTL_HI]; // RULE2
          end
          mode_lo_next = wdata[serial_port_pkg::CTL_LO];
          mp_next = wdata[serial_port_pkg::CTL_MP];
          ren_next = wdata[serial_port_pkg::CTL_REN];
          tx9_next = wdata[serial_port_pkg::CTL_TX9]; // RULE9
          rx9_next = wdata[serial_port_pkg::CTL_RX9];
          txf_next = wdata[serial_port_pkg::CTL_TXF]; // RULE12
          rxf_next = wdata[serial_port_pkg::CTL_RXF]; // RULE14
        end
        serial_port_pkg::IDX_POWER: begin
          dbl_next = wdata[serial_port_pkg::PC_DOUBLE];
          fsel_next = wdata[serial_port_pkg::PC_FSEL];
        end
        serial_port_pkg::IDX_BAUD: baud_next = wdata;
        serial_port_pkg::IDX_IMASK: imask_next = wdata[IRQ_W_L-1:0];
        serial_port_pkg::IDX_ISTAT: istat_next = istat_reg & ~wdata[IRQ_W_L-1:0];
        default: ;
      endcase
    end
    // Transmitter; a write while busy is dropped
    case (tx_st_reg)
      TX_IDLE: begin
        if (a_wr_reg && a_idx_reg == serial_port_pkg::IDX_DATA) begin // RULE16
          tx_st_next = TX_SEND; // RULE17
          tx_cnt_next = per - 16'h0001;
          tx_idx_next = 4'h0;
          case (mode)
            serial_port_pkg::MODE_SYNC: tx_sh_next = {3'h7, wdata};
            serial_port_pkg::MODE_ASYNC10: tx_sh_next = {2'h3, wdata, 1'b0};
            default: tx_sh_next = {1'b1, tx9_reg, wdata, 1'b0}; // RULE9
          endcase
        end
      end
      TX_SEND: begin
        if (tx_cnt_reg == 16'h0000) begin
          tx_cnt_next = per - 16'h0001;
          tx_sh_next = {1'b1, tx_sh_reg[10:1]};
          tx_idx_next = tx_idx_reg + 4'h1;
          if (mode == serial_port_pkg::MODE_SYNC) begin
            if (tx_idx_reg == nb - 4'h1) begin
              tx_ev = 1'b1; // RULE11
              tx_st_next = TX_IDLE;
            end
          end else begin
            if (tx_idx_reg == nb - 4'h2) begin
              tx_ev = 1'b1; // RULE11
            end
            if (tx_idx_reg == nb - 4'h1) begin
              tx_st_next = TX_IDLE;
            end
          end
        end else begin
          tx_cnt_next = tx_cnt_reg - 16'h0001;
        end
      end
      default: tx_st_next = TX_IDLE;
    endcase
    // Receiver; sync mode only starts while receive-done is clear
    case (rx_st_reg)
      RX_IDLE: begin
        if (ren_reg) begin // RULE8
          if (mode == serial_port_pkg::MODE_SYNC) begin
            if (!rxf_reg && tx_st_reg == TX_IDLE && tx_st_next == TX_IDLE) begin
              rx_st_next = RX_RUN;
              rx_cnt_next = per - 16'h0001;
              rx_idx_next = 4'h0;
            end
          end else if (rxd_s3_reg && !rxd_s2_reg) begin
            rx_st_next = RX_RUN;
            rx_cnt_next = half;
            rx_idx_next = 4'h0;
          end
        end
      end
      RX_RUN: begin
        if (!ren_reg) begin
          rx_st_next = RX_IDLE; // RULE8
        end else if (rx_cnt_reg != 16'h0000) begin
          rx_cnt_next = rx_cnt_reg - 16'h0001;
        end else begin
          rx_cnt_next = per - 16'h0001;
          rx_idx_next = rx_idx_reg + 4'h1;
          if (mode == serial_port_pkg::MODE_SYNC) begin
            rx_data_next[rx_idx_reg[2:0]] = rxd_s2_reg;
            if (rx_idx_reg == nb - 4'h1) begin
              rbuf_next = rx_data_next;
              rx_ev = 1'b1; // RULE13
              rx_st_next = RX_IDLE;
            end
          end else if (rx_idx_reg == 4'h0) begin
            if (rxd_s2_reg) begin
              rx_st_next = RX_IDLE;
            end
          end else if (rx_idx_reg <= serial_port_pkg::LAST_DATA_IDX) begin
            rx_data_next[3'(rx_idx_reg - 4'h1)] = rxd_s2_reg;
          end else if (rx_idx_reg == nb - 4'h1) begin
            rx_st_next = RX_IDLE;
            if (fsel_reg && !stop_bit) begin
              ferr_ev = 1'b1; // RULE3
            end
            if (mode == serial_port_pkg::MODE_ASYNC10) begin
              accept = !mp_reg || stop_bit; // RULE6
            end else begin
              accept = !mp_reg || nine_reg; // RULE5
            end
            if (accept) begin
              rbuf_next = rx_data_reg;
              rx_ev = 1'b1; // RULE13
              if (mode != serial_port_pkg::MODE_ASYNC10) begin
                rx9_next = nine_reg; // RULE10
              end else if (!mp_reg) begin
                rx9_next = stop_bit; // RULE10
              end
            end
          end else if (rx_idx_reg == serial_port_pkg::NINTH_IDX) begin
            nine_next = rxd_s2_reg;
          end
        end
      end
      default: rx_st_next = RX_IDLE;
    endcase
    if (tx_ev) begin
      txf_next = 1'b1;
    end
    if (rx_ev) begin
      rxf_next = 1'b1;
    end
    if (ferr_ev) begin
      ferr_next = 1'b1;
    end
    istat_next[serial_port_pkg::IRQ_TX] = istat_next[serial_port_pkg::IRQ_TX] | tx_ev;
    istat_next[serial_port_pkg::IRQ_RX] = istat_next[serial_port_pkg::IRQ_RX] | rx_ev;
    istat_next[serial_port_pkg::IRQ_FERR] = istat_next[serial_port_pkg::IRQ_FERR] | ferr_ev;
    irq_next = |(istat_next & imask_next);
    // Pins; in mode 0 txd is the shift clock, low first and rising in the middle of a bit
    txd_next = 1'b1;
    rxd_out_next = 1'b1;
    rxd_oe_next = 1'b0;
    if (mode == serial_port_pkg::MODE_SYNC) begin
      if (tx_st_next == TX_SEND) begin
        rxd_oe_next = 1'b1;
        rxd_out_next = tx_sh_next[0];
        txd_next = tx_cnt_next < half;
      end else if (rx_st_next == RX_RUN) begin
        txd_next = rx_cnt_next < half;
      end
    end else if (tx_st_next == TX_SEND) begin
      txd_next = tx_sh_next[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_hi_reg <= 1'b0;
      mode_lo_reg <= 1'b0;
      mp_reg <= 1'b0;
      ren_reg <= 1'b0;
      tx9_reg <= 1'b0;
      rx9_reg <= 1'b0;
      txf_reg <= 1'b0;
      rxf_reg <= 1'b0;
      ferr_reg <= 1'b0;
      dbl_reg <= 1'b0;
      fsel_reg <= 1'b0;
      baud_reg <= serial_port_pkg::BAUD_RESET;
      rbuf_reg <= 8'h00;
      imask_reg <= serial_port_pkg::IRQ_RESET;
      istat_reg <= serial_port_pkg::IRQ_RESET;
      tx_st_reg <= TX_IDLE;
      rx_st_reg <= RX_IDLE;
      tx_sh_reg <= 11'h7ff;
      tx_cnt_reg <= 16'h0000;
      rx_cnt_reg <= 16'h0000;
      tx_idx_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_data_reg <= 8'h00;
      nine_reg <= 1'b0;
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
      rxd_s3_reg <= 1'b1;
      txd_reg <= 1'b1;
      rxd_out_reg <= 1'b1;
      rxd_oe_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      mode_hi_reg <= mode_hi_next;
      mode_lo_reg <= mode_lo_next;
      mp_reg <= mp_next;
      ren_reg <= ren_next;
      tx9_reg <= tx9_next;
      rx9_reg <= rx9_next;
      txf_reg <= txf_next;
      rxf_reg <= rxf_next;
      ferr_reg <= ferr_next;
      dbl_reg <= dbl_next;
      fsel_reg <= fsel_next;
      baud_reg <= baud_next;
      rbuf_reg <= rbuf_next;
      imask_reg <= imask_next;
      istat_reg <= istat_next;
      tx_st_reg <= tx_st_next;
      rx_st_reg <= rx_st_next;
      tx_sh_reg <= tx_sh_next;
      tx_cnt_reg <= tx_cnt_next;
      rx_cnt_reg <= rx_cnt_next;
      tx_idx_reg <= tx_idx_next;
      rx_idx_reg <= rx_idx_next;
      rx_data_reg <= rx_data_next;
      nine_reg <= nine_next;
      rxd_s1_reg <= rxd_in;
      rxd_s2_reg <= rxd_s1_reg;
      rxd_s3_reg <= rxd_s2_reg;
      txd_reg <= txd_next;
      rxd_out_reg <= rxd_out_next;
      rxd_oe_reg <= rxd_oe_next;
      irq_reg <= irq_next;
    end
  end

  assign hreadyout = hready_reg;
  assign hrdata = hrdata_reg;
  assign hresp = 1'b0;
  assign txd = txd_reg;
  assign rxd_out = rxd_out_reg;
  assign rxd_oe = rxd_oe_reg;
  assign irq = irq_reg;
endmodule // serial_port_ctrl

//--- rtl/serial_port_pkg.sv
package serial_port_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_POWER = 8'h87;
  localparam logic [7:0] IDX_CTRL = 8'h98;
  localparam logic [7:0] IDX_DATA = 8'h99;
  localparam logic [7:0] IDX_BAUD = 8'hf0;
  localparam logic [7:0] IDX_ISTAT = 8'hf1;
  localparam logic [7:0] IDX_IMASK = 8'hf2;
  localparam logic [7:0] IDX_NONE = 8'h00;
  localparam int ADDR_HI = 9;
  localparam int ADDR_LO = 2;
  // Control register fields
  localparam int CTL_HI = 7;
  localparam int CTL_LO = 6;
  localparam int CTL_MP = 5;
  localparam int CTL_REN = 4;
  localparam int CTL_TX9 = 3;
  localparam int CTL_RX9 = 2;
  localparam int CTL_TXF = 1;
  localparam int CTL_RXF = 0;
  // Power control fields
  localparam int PC_DOUBLE = 7;
  localparam int PC_FSEL = 6;
  // Interrupt status and mask fields
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_FERR = 2;
  localparam int IRQ_W = 3;
  // Reset values
  localparam logic [7:0] BAUD_RESET = 8'h0f;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  // Modes
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_ASYNC10 = 2'h1;
  localparam logic [1:0] MODE_FIXED11 = 2'h2;
  localparam logic [1:0] MODE_VAR11 = 2'h3;
  // Clocks per bit
  localparam logic [15:0] M0_SLOW = 16'h000c;
  localparam logic [15:0] M0_FAST = 16'h0004;
  localparam logic [15:0] M2_SLOW = 16'h0040;
  localparam logic [15:0] M2_FAST = 16'h0020;
  // Bits per frame and index of the ninth data bit
  localparam logic [3:0] NB_SYNC = 4'h8;
  localparam logic [3:0] NB_TEN = 4'ha;
  localparam logic [3:0] NB_ELEVEN = 4'hb;
  localparam logic [3:0] NINTH_IDX = 4'h9;
  localparam logic [3:0] LAST_DATA_IDX = 4'h8;
endpackage

//--- bench/serial_port_ctrl_checker.sv
`timescale 1ns/1ps
module serial_port_ctrl_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // Serial and interrupt
  input wire logic txd,
  input wire logic irq
);
  logic rd_take;
  logic wr_take;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (wr_take |=> hreadyout)
    else $error("write stalled");
  a_stall_cause: assert property ($fell(hreadyout) |-> $past(rd_take))
    else $error("stall without read");
  a_rdata_hold: assert property ((hreadyout && $past(hreadyout)) |-> $stable(hrdata))
    else $error("read data moved");
  a_byte_lane: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  a_low_hold: assert property ($fell(txd) |=> !txd)
    else $error("txd low glitch");
  a_high_hold: assert property ($rose(txd) |=> txd)
    else $error("txd high glitch");

  c_read: cover property (rd_take);
  c_irq: cover property ($rose(irq));
  c_frame: cover property ($fell(txd));
endmodule // serial_port_ctrl_checker

//--- bench/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
  // Bench clock
  input wire logic clk,
  // Serial lines
  output logic line_out,
  input wire logic line_in
);
  initial line_out = 1'b1;

  task automatic send(input logic [8:0] d, input int nd, input logic stop, input int cpb);
    int i;
    @(posedge clk);
    line_out <= 1'b0;
    repeat (cpb) @(posedge clk);
    for (i = 0; i < nd; i++) begin
      line_out <= d[i];
      repeat (cpb) @(posedge clk);
    end
    line_out <= stop;
    repeat (cpb) @(posedge clk);
    // Line pulled high when idle
    line_out <= 1'b1;
    repeat (cpb) @(posedge clk);
  endtask

  // Samples mid-bit; unknown result if no start bit shows up
  task automatic recv(input int nb, input int cpb, output logic [10:0] f);
    int i;
    int n;
    f = 'x;
    n = 0;
    while (line_in !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (line_in === 1'b0) begin
      repeat (cpb / 2) @(posedge clk);
      for (i = 0; i < nb; i++) begin
        repeat (cpb) @(posedge clk);
        f[i] = line_in;
      end
    end
  endtask
endmodule // serial_peer

//--- bench/serial_port_ctrl_bench.sv
`timescale 1ns/1ps
module serial_port_ctrl_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic rxd_line;
  logic rxd_wire;
  logic rxd_out;
  logic rxd_oe;
  logic txd;
  logic irq;
  logic [10:0] fr;
  int fails = 0;
  int n_compared = 0;

  assign hready = hreadyout;
  assign rxd_wire = rxd_oe ? rxd_out : rxd_line;
  always #25 hclk = ~hclk;

  serial_port_ctrl u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rxd_in(rxd_wire),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .irq(irq)
  );
  serial_peer u_peer (.clk(hclk), .line_out(rxd_line), .line_in(txd));

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      fails++;
      wrap_up();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
    bus(1'b0, idx, 8'h00);
    chk(what, {24'h0, exp}, q);
  endtask

  task automatic t_reset();
    rd(serial_port_pkg::IDX_CTRL, 8'h00, "ctrl reset");
    rd(serial_port_pkg::IDX_BAUD, serial_port_pkg::BAUD_RESET, "baud reset");
    rd(serial_port_pkg::IDX_DATA, 8'h00, "rx buffer reset");
    wr(serial_port_pkg::IDX_NONE, 8'hff);
    rd(serial_port_pkg::IDX_NONE, 8'h00, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_mode0();
    int k;
    int n;
    for (k = 0; k < 2; k++) begin
      wr(serial_port_pkg::IDX_CTRL, k ? 8'h20 : 8'h00);
      wr(serial_port_pkg::IDX_DATA, 8'h01);
      n = 0;
      while (txd !== 1'b0 && n < 50) begin
        @(posedge hclk);
        n++;
      end
      chk("mode0 drives rxd", 32'h1, {31'h0, rxd_oe});
      chk("mode0 first data bit", 32'h1, {31'h0, rxd_out});
      n = 0;
      while (txd === 1'b0 && n < 50) begin
        @(posedge hclk);
        n++;
      end
      chk("shift clock low", k ? 32'h2 : 32'h6, n);
      repeat (120) @(posedge hclk);
      rd(serial_port_pkg::IDX_CTRL, k ? 8'h22 : 8'h02, "mode0 tx done");
      wr(serial_port_pkg::IDX_CTRL, k ? 8'h20 : 8'h00);
    end
    $display("test mode0 done");
  endtask

  task automatic t_tx();
    wr(serial_port_pkg::IDX_POWER, 8'h80);
    wr(serial_port_pkg::IDX_CTRL, 8'h88);
    fork
      u_peer.recv(10, 32, fr);
      begin
        wr(serial_port_pkg::IDX_DATA, 8'ha5);
        rd(serial_port_pkg::IDX_CTRL, 8'h88, "tx done early");
      end
    join
    chk("frame data", 32'ha5, {24'h0, fr[7:0]});
    chk("ninth bit", 32'h1, {31'h0, fr[8]});
    chk("stop bit", 32'h1, {31'h0, fr[9]});
    rd(serial_port_pkg::IDX_CTRL, 8'h8a, "tx done");
    rd(serial_port_pkg::IDX_ISTAT, 8'h01, "tx status");
    wr(serial_port_pkg::IDX_IMASK, 8'h01);
    repeat (2) @(posedge hclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(serial_port_pkg::IDX_ISTAT, 8'h01);
    repeat (2) @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(serial_port_pkg::IDX_CTRL, 8'h88);
    rd(serial_port_pkg::IDX_CTRL, 8'h88, "tx done cleared");
    $display("test transmit done");
  endtask

  task automatic t_rx();
    wr(serial_port_pkg::IDX_POWER, 8'h00);
    wr(serial_port_pkg::IDX_CTRL, 8'hb0);
    u_peer.send(9'h03c, 9, 1'b1, 64);
    rd(serial_port_pkg::IDX_CTRL, 8'hb0, "address filter");
    u_peer.send(9'h15a, 9, 1'b1, 64);
    rd(serial_port_pkg::IDX_CTRL, 8'hb5, "rx done ninth");
    rd(serial_port_pkg::IDX_DATA, 8'h5a, "rx data");
    wr(serial_port_pkg::IDX_CTRL, 8'ha0);
    u_peer.send(9'h111, 9, 1'b1, 64);
    rd(serial_port_pkg::IDX_CTRL, 8'ha0, "rx disabled");
    rd(serial_port_pkg::IDX_DATA, 8'h5a, "rx data kept");
    // Mode 3 at reload 7: 16 clocks per bit
    wr(serial_port_pkg::IDX_BAUD, 8'h07);
    wr(serial_port_pkg::IDX_CTRL, 8'hd0);
    u_peer.send(9'h0c3, 9, 1'b1, 16);
    rd(serial_port_pkg::IDX_CTRL, 8'hd1, "mode3 rx done");
    rd(serial_port_pkg::IDX_DATA, 8'hc3, "mode3 rx data");
    wr(serial_port_pkg::IDX_BAUD, serial_port_pkg::BAUD_RESET);
    $display("test receive done");
  endtask

  task automatic t_frame();
    wr(serial_port_pkg::IDX_CTRL, 8'h70);
    wr(serial_port_pkg::IDX_POWER, 8'h40);
    u_peer.send(9'h077, 8, 1'b0, 32);
    rd(serial_port_pkg::IDX_CTRL, 8'hf0, "framing flag");
    u_peer.send(9'h066, 8, 1'b1, 32);
    rd(serial_port_pkg::IDX_CTRL, 8'hf1, "flag kept");
    rd(serial_port_pkg::IDX_DATA, 8'h66, "rx data mode1");
    rd(serial_port_pkg::IDX_ISTAT, 8'h06, "rx framing status");
    wr(serial_port_pkg::IDX_CTRL, 8'h70);
    rd(serial_port_pkg::IDX_CTRL, 8'h70, "flag cleared");
    $display("test framing done");
  endtask

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_mode0();
    t_tx();
    t_rx();
    t_frame();
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge hclk);
    fails++;
    wrap_up();
  end
endmodule // serial_port_ctrl_bench

bind serial_port_ctrl serial_port_ctrl_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .txd(txd), .irq(irq)
);
